// ---- pkg/dsadc_pkg.sv ----
// constants and types for the oversampling converter control block
package dsadc_pkg;
   // ------------------------------------------------------------------
   // bus and data widths
   // ------------------------------------------------------------------
   localparam int ADDR_W   = 4;
   localparam int DATA_W   = 16;
   localparam int RES_W    = 12;
   localparam int CNT_W    = 9;
   localparam int SUM_W    = 11;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } dsadc_bus_t;

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_MULTI  = 2'b01,
      MODE_CONT   = 2'b10,
      MODE_TURBO  = 2'b11
   } dsadc_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01,
      ST_HOLD = 2'b10
   } dsadc_state_t;

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h1;
   localparam logic [ADDR_W-1:0] REG_RESULT   = 4'h2;
   localparam logic [ADDR_W-1:0] REG_INT_STAT = 4'h3;
   localparam logic [ADDR_W-1:0] REG_INT_EN   = 4'h4;
   localparam logic [ADDR_W-1:0] REG_INT_CLR  = 4'h5;

   // ------------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------------
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_RES8_BIT  = 2;
   localparam int CTRL_START_BIT = 3;
   localparam int CTRL_STOP_BIT  = 4;
   localparam int STAT_EOC_BIT   = 0;
   localparam int STAT_BUSY_BIT  = 1;
   localparam int INT_EOC_BIT    = 0;
   localparam int INT_OVR_BIT    = 1;
   localparam int INT_W          = 2;
   localparam dsadc_mode_t      MODE_RST   = MODE_SINGLE;
   localparam logic [INT_W-1:0] INT_EN_RST = 2'h0;

   // ------------------------------------------------------------------
   // timing: modulator bit period and decimation lengths
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int MOD_PERIOD_NS = 20;
   localparam int MOD_DIV       = (MOD_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] OSR_HI = 9'h100;
   localparam logic [CNT_W-1:0] OSR_LO = 9'h080;
   localparam logic [1:0]       PRIME_CONV = 2'h3;
endpackage

// ---- hdl/dsadc_ctrl.sv ----
// conversion sequencer and decimator for the oversampling converter
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module dsadc_ctrl (
   // clock and reset
   input  wire logic                       i_ref_clk,
   input  wire logic                       i_srst,
   // register port
   input  wire dsadc_pkg::dsadc_bus_t      i_bus,
   output logic [dsadc_pkg::DATA_W-1:0]    o_rdata,
   // converter side
   input  wire logic                       i_mod_bit,
   input  wire logic                       i_soc,
   input  wire logic                       i_chan_sw,
   // events
   output logic                            o_eoc,
   output logic                            o_irq
);
   import dsadc_pkg::*;

   // ------------------------------------------------------------------
   // synchronisers and modulator sample enable
   // ------------------------------------------------------------------
   logic soc_s1_q, soc_s2_q, soc_s3_q, mod_s1_q, mod_s2_q;
   logic [3:0] div_q;
   logic       mod_en_q;

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         soc_s1_q <= 1'b0;
         soc_s2_q <= 1'b0;
         soc_s3_q <= 1'b0;
         mod_s1_q <= 1'b0;
         mod_s2_q <= 1'b0;
      end else begin
         soc_s1_q <= i_soc;
         soc_s2_q <= soc_s1_q;
         soc_s3_q <= soc_s2_q;
         mod_s1_q <= i_mod_bit;
         mod_s2_q <= mod_s1_q;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         div_q    <= 4'h0;
         mod_en_q <= 1'b0;
      end else begin
         mod_en_q <= (div_q == 4'(MOD_DIV - 1));
         div_q    <= (div_q == 4'(MOD_DIV - 1)) ? 4'h0 : div_q + 4'h1;
      end
   end

   // ------------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------------
   dsadc_mode_t       mode_q;
   logic              res8_q;
   logic [INT_W-1:0]  int_en_q, int_stat_q;
   logic              wr_ctrl, sw_start, sw_stop, rd_result, soc_rise, start_req;

   assign wr_ctrl   = i_bus.wr && (i_bus.addr == REG_CTRL);
   assign sw_start  = wr_ctrl && i_bus.wdata[CTRL_START_BIT];
   assign sw_stop   = wr_ctrl && i_bus.wdata[CTRL_STOP_BIT];
   assign rd_result = i_bus.rd && (i_bus.addr == REG_RESULT);
   assign soc_rise  = soc_s2_q && !soc_s3_q;
   assign start_req = sw_start || soc_rise;

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         mode_q   <= MODE_RST;
         res8_q   <= 1'b0;
         int_en_q <= INT_EN_RST;
      end else begin
         if (wr_ctrl) begin
            mode_q <= dsadc_mode_t'(i_bus.wdata[CTRL_MODE_LSB +: 2]);
            res8_q <= i_bus.wdata[CTRL_RES8_BIT];
         end
         if (i_bus.wr && (i_bus.addr == REG_INT_EN)) begin
            int_en_q <= i_bus.wdata[INT_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------
   dsadc_state_t      state_q;
   logic [CNT_W-1:0]  bit_cnt_q, ones_q, osr;
   logic [1:0]        prime_q;
   logic              conv_done, result_ev, multi_md;

   assign osr       = res8_q ? OSR_LO : OSR_HI;
   assign conv_done = (state_q == ST_RUN) && mod_en_q && (bit_cnt_q == osr - 9'h001);
   assign result_ev = conv_done && (prime_q == PRIME_CONV) && !i_chan_sw && !sw_stop;
   assign multi_md  = (mode_q == MODE_MULTI) || (mode_q == MODE_TURBO);

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         state_q <= ST_IDLE;
      end else if (sw_stop) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start_req) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (result_ev && mode_q == MODE_SINGLE) begin
                  state_q <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (rd_result) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst || state_q != ST_RUN || i_chan_sw) begin
         bit_cnt_q <= 9'h000;
         ones_q    <= 9'h000;
      end else if (mod_en_q) begin
         bit_cnt_q <= conv_done ? 9'h000 : bit_cnt_q + 9'h001;
         ones_q    <= conv_done ? 9'h000 : ones_q + {8'h00, mod_s2_q};
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst || state_q == ST_IDLE || i_chan_sw) begin
         prime_q <= 2'h0;
      end else if (result_ev && multi_md) begin
         prime_q <= 2'h0;
      end else if (conv_done && prime_q != PRIME_CONV) begin
         prime_q <= prime_q + 2'h1;
      end
   end

   // ------------------------------------------------------------------
   // decimator: sum of last four conversions
   // ------------------------------------------------------------------
   logic [CNT_W-1:0] hist_q [3];
   logic [SUM_W-1:0] sum;
   logic [RES_W-1:0] res_w, result_q;
   logic [CNT_W-1:0] last;

   assign last = ones_q + {8'h00, mod_s2_q};
   assign sum  = SUM_W'(last) + SUM_W'(hist_q[0]) + SUM_W'(hist_q[1]) + SUM_W'(hist_q[2]);

   always_comb begin
      if (res8_q) begin
         // 8-bit full scale is a sum of 512
         res_w = sum[9] ? 12'h0FF : {4'h0, sum[8:1]};
      end else begin
         res_w = sum[SUM_W-1] ? 12'hFFF : {sum[9:0], 2'h0};
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst || state_q == ST_IDLE) begin
         hist_q[0] <= 9'h000;
         hist_q[1] <= 9'h000;
         hist_q[2] <= 9'h000;
      end else if (conv_done) begin
         hist_q[0] <= last;
         hist_q[1] <= hist_q[0];
         hist_q[2] <= hist_q[1];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         result_q <= 12'h000;
      end else if (result_ev) begin
         result_q <= res_w;
      end
   end

   // ------------------------------------------------------------------
   // end of conversion and interrupts
   // ------------------------------------------------------------------
   logic eoc_q, irq_q;
   logic [INT_W-1:0] int_clr, int_set;

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         eoc_q <= 1'b0;
      end else if (result_ev) begin
         eoc_q <= 1'b1;
      end else if (rd_result) begin
         eoc_q <= 1'b0;
      end
   end

   assign int_clr = (i_bus.wr && i_bus.addr == REG_INT_CLR) ? i_bus.wdata[INT_W-1:0] : 2'h0;
   assign int_set = {result_ev && eoc_q && !rd_result, result_ev};

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         int_stat_q <= 2'h0;
         irq_q      <= 1'b0;
      end else begin
         int_stat_q <= (int_stat_q & ~int_clr) | int_set;
         irq_q      <= |(((int_stat_q & ~int_clr) | int_set) & int_en_q);
      end
   end

   // ------------------------------------------------------------------
   // read data
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] rdata_q;

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         rdata_q <= 16'h0000;
      end else if (i_bus.rd) begin
         unique case (i_bus.addr)
            REG_CTRL:     rdata_q <= {13'h0000, res8_q, mode_q};
            REG_STATUS:   rdata_q <= {14'h0000, state_q != ST_IDLE, eoc_q};
            REG_RESULT:   rdata_q <= {4'h0, result_q};
            REG_INT_STAT: rdata_q <= {14'h0000, int_stat_q};
            REG_INT_EN:   rdata_q <= {14'h0000, int_en_q};
            default:      rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign o_rdata = rdata_q;
   assign o_eoc   = eoc_q;
   assign o_irq   = irq_q;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   property p_eoc_held;
      eoc_q && !rd_result |=> eoc_q;
   endproperty
   a_eoc_held: assert property (p_eoc_held) else $error("eoc dropped before read");

   property p_eoc_rise;
      result_ev |=> eoc_q && result_q == $past(res_w);
   endproperty
   a_eoc_rise: assert property (p_eoc_rise) else $error("eoc or result missing");

   property p_start;
      state_q == ST_IDLE && start_req && !sw_stop |=> state_q == ST_RUN;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_standby;
      state_q == ST_IDLE && !start_req |=> state_q == ST_IDLE && !conv_done;
   endproperty
   a_standby: assert property (p_standby) else $error("left standby");

   property p_single_hold;
      result_ev && mode_q == MODE_SINGLE |=> state_q == ST_HOLD;
   endproperty
   a_single_hold: assert property (p_single_hold) else $error("single no hold");

   property p_primed;
      result_ev |-> prime_q == 2'h3 && $past(conv_done, 1) == 1'b0;
   endproperty
   a_primed: assert property (p_primed) else $error("result before priming");

   property p_multi_auto;
      result_ev && multi_md |=> state_q == ST_RUN && prime_q == 2'h0;
   endproperty
   a_multi_auto: assert property (p_multi_auto) else $error("multi not restarted");

   property p_return;
      state_q == ST_HOLD && rd_result && !sw_stop |=> state_q == ST_IDLE ##1 !eoc_q;
   endproperty
   a_return: assert property (p_return) else $error("no return to standby");

   property p_ignore;
      state_q == ST_RUN && start_req && !conv_done && !i_chan_sw && !sw_stop
         |=> state_q == ST_RUN && $stable(prime_q);
   endproperty
   a_ignore: assert property (p_ignore) else $error("start not ignored");

   property p_switch;
      i_chan_sw |=> prime_q == 2'h0 && !result_ev;
   endproperty
   a_switch: assert property (p_switch) else $error("switch kept priming");

   property p_restart;
      i_chan_sw && state_q == ST_RUN && !sw_stop |=> bit_cnt_q == 9'h000 && prime_q == 2'h0;
   endproperty
   a_restart: assert property (p_restart) else $error("switch kept old bits");

   property p_sat8;
      result_ev && res8_q && sum >= 11'h1FE |=> result_q == 12'h0FF;
   endproperty
   a_sat8: assert property (p_sat8) else $error("8-bit result not saturated");

   c_single: cover property (state_q == ST_HOLD && rd_result);
   c_cont:   cover property (result_ev && mode_q == MODE_CONT ##[1:600] result_ev);
   c_multi:  cover property (result_ev && multi_md);
   c_ovr:    cover property (int_set[INT_OVR_BIT]);
endmodule

// ---- tb/dsadc_mod_src.sv ----
// far-side model: modulator bitstream and trigger source
`timescale 1ns/1ps
module dsadc_mod_src
   import dsadc_pkg::*;
(
   // clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_srst,
   // control from bench
   input  wire logic [1:0] i_pattern,
   input  wire logic       i_fire,
   // to converter
   output logic            o_mod_bit,
   output logic            o_soc
);
   logic [1:0] div_q;
   logic       phase_q;
   logic [2:0] soc_q;

   // 0 zeros, 1 ones, 2 and 3 alternate each modulator bit
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || div_q == 2'(MOD_DIV - 1)) begin
         div_q   <= 2'h0;
         phase_q <= i_srst ? 1'b0 : ~phase_q;
      end else begin
         div_q <= div_q + 2'h1;
      end
   end
   assign o_mod_bit = i_pattern[1] ? (phase_q ^ i_pattern[0]) : i_pattern[0];

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         soc_q <= 3'h0;
      end else if (i_fire) begin
         soc_q <= 3'h4;
      end else if (soc_q != 3'h0) begin
         soc_q <= soc_q - 3'h1;
      end
   end
   assign o_soc = (soc_q != 3'h0);
endmodule

// ---- tb/dsadc_ctrl_tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
module dsadc_ctrl_tb;
   import dsadc_pkg::*;
   typedef struct {
      dsadc_mode_t mode;
      logic        res8;
      logic [1:0]  pat;
      logic [15:0] exp;
      int          lo;
      int          hi;
   } dsadc_row_t;
   logic        i_ref_clk = 1'b0;
   logic        i_srst    = 1'b1;
   dsadc_bus_t  bus       = '0;
   logic [15:0] o_rdata;
   logic        mod_bit;
   logic        soc;
   logic        chan      = 1'b0;
   logic        o_eoc;
   logic        o_irq;
   logic [1:0]  pat       = 2'h2;
   logic        fire      = 1'b0;
   logic [15:0] d;
   int          n;
   int          cyc = 0;
   int          stamp;
   int          n_errors = 0;
   int          checks_done = 0;
   logic [3:0]  regs [7] = '{REG_CTRL, REG_STATUS, REG_RESULT, REG_INT_STAT, REG_INT_EN,
                             REG_INT_CLR, 4'hF};
   dsadc_row_t  rows [7] = '{
      '{MODE_SINGLE, 1'b0, 2'h2, 16'h0800, 3000, 3000},
      '{MODE_SINGLE, 1'b0, 2'h1, 16'h0FFF, 3000, 3000},
      '{MODE_SINGLE, 1'b1, 2'h2, 16'h0080, 3000, 3000},
      '{MODE_SINGLE, 1'b1, 2'h1, 16'h00FF, 3000, 3000},
      '{MODE_MULTI,  1'b0, 2'h0, 16'h0000, 2020, 2064},
      '{MODE_CONT,   1'b0, 2'h2, 16'h0800, 490,  520},
      '{MODE_TURBO,  1'b0, 2'h2, 16'h0800, 2020, 2064}};

   dsadc_ctrl i_dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_bus(bus), .o_rdata(o_rdata),
      .i_mod_bit(mod_bit), .i_soc(soc), .i_chan_sw(chan), .o_eoc(o_eoc), .o_irq(o_irq));
   dsadc_mod_src i_src (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_pattern(pat),
      .i_fire(fire), .o_mod_bit(mod_bit), .o_soc(soc));

   initial begin
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   always @(posedge i_ref_clk) cyc <= cyc + 1;

   // ------------------------------------------------------------------
   // bus and compare tasks
   // ------------------------------------------------------------------
   function automatic logic [15:0] ctrl_w(dsadc_mode_t m, logic r8, logic go, logic halt);
      return {11'h000, halt, go, r8, m};
   endfunction
   task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge i_ref_clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge i_ref_clk);
      bus.wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge i_ref_clk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_ref_clk);
      bus.rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic chk_span(input int got, input int lo, input int hi);
      checks_done++;
      if (got < lo || got > hi) begin
         n_errors++;
         $display("unexpected at %0t: %0d cycles, wanted %0d to %0d", $time, got, lo, hi);
      end
   endtask
   task automatic wait_eoc(output int k);
      k = 0;
      while (o_eoc !== 1'b1 && k < 3000) begin
         @(posedge i_ref_clk);
         #1 k++;
      end
   endtask
   task automatic final_report();
      if (n_errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #800_000;
      n_errors++;
      final_report();
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (6) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      foreach (rows[i]) begin
         @(posedge i_ref_clk);
         pat <= rows[i].pat;
         bus_wr(REG_CTRL, ctrl_w(rows[i].mode, rows[i].res8, 1'b1, 1'b0));
         wait_eoc(n);
         chk_span(n, rows[i].res8 ? 1010 : 2030, rows[i].res8 ? 1040 : 2064);
         chk_bit(o_irq, 1'b0);
         bus_rd(REG_STATUS, d);
         chk_word(d & 16'h0001, 16'h0001);
         bus_rd(REG_RESULT, d);
         chk_word(d, rows[i].exp);
         chk_bit(o_eoc, 1'b0);
         wait_eoc(n);
         chk_span(n, rows[i].lo, rows[i].hi);
         if (rows[i].mode != MODE_SINGLE) begin
            bus_rd(REG_RESULT, d);
            chk_word(d, rows[i].exp);
            bus_wr(REG_CTRL, ctrl_w(rows[i].mode, 1'b0, 1'b0, 1'b1));
         end
         repeat (2) @(posedge i_ref_clk);
         bus_rd(REG_STATUS, d);
         chk_word(d & 16'h0003, 16'h0000);
      end
      // trigger start, second start ignored, interrupt raised and cleared
      bus_wr(REG_INT_CLR, 16'h0003);
      bus_rd(REG_INT_STAT, d);
      chk_word(d, 16'h0000);
      bus_wr(REG_INT_EN, 16'h0001);
      @(posedge i_ref_clk);
      fire <= 1'b1;
      stamp = cyc;
      @(posedge i_ref_clk);
      fire <= 1'b0;
      repeat (200) @(posedge i_ref_clk);
      bus_wr(REG_CTRL, ctrl_w(MODE_SINGLE, 1'b0, 1'b1, 1'b0));
      wait_eoc(n);
      chk_span(cyc - stamp, 2030, 2075);
      repeat (2) @(posedge i_ref_clk);
      #1 chk_bit(o_irq, 1'b1);
      bus_rd(REG_INT_STAT, d);
      chk_word(d, 16'h0001);
      bus_rd(REG_RESULT, d);
      chk_word(d, 16'h0800);
      bus_wr(REG_INT_CLR, 16'h0001);
      repeat (2) @(posedge i_ref_clk);
      #1 chk_bit(o_irq, 1'b0);
      // input switch in continuous mode restarts priming
      bus_wr(REG_CTRL, ctrl_w(MODE_CONT, 1'b0, 1'b1, 1'b0));
      wait_eoc(n);
      chk_span(n, 2030, 2064);
      bus_rd(REG_RESULT, d);
      chk_word(d, 16'h0800);
      @(posedge i_ref_clk);
      chan <= 1'b1;
      pat  <= 2'h1;
      @(posedge i_ref_clk);
      chan <= 1'b0;
      wait_eoc(n);
      chk_span(n, 2000, 2600);
      bus_rd(REG_RESULT, d);
      chk_word(d, 16'h0FFF);
      // unread results raise overrun
      repeat (1100) @(posedge i_ref_clk);
      bus_rd(REG_INT_STAT, d);
      chk_word(d, 16'h0003);
      // reset in mid-run, then reset values and unmapped access
      repeat (100) @(posedge i_ref_clk);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      bus_wr(4'hF, 16'hFFFF);
      foreach (regs[i]) begin
         bus_rd(regs[i], d);
         chk_word(d, 16'h0000);
      end
      chk_bit(o_eoc, 1'b0);
      chk_bit(o_irq, 1'b0);
      final_report();
   end
endmodule
